// File: shared/level_select_if.sv
// Purpose: carries level sets and pin state to the level selector
// Assumes: all signals on mclk
// Notes: selector is purely combinational
`timescale 1ns/100ps
interface level_select_if;
   logic [limiting_amp_pkg::NUM_SETS-1:0] setSelect;
   logic [limiting_amp_pkg::LEVEL_W-1:0] setCode [limiting_amp_pkg::NUM_SETS];
   logic pinHigh;
   logic pinLow;
   logic [limiting_amp_pkg::LEVEL_W-1:0] activeCode;
   logic usingDefault;
   limiting_amp_pkg::level_set_e activeSet;

   modport bank (output setSelect, output setCode, output pinHigh,
      output pinLow, input activeCode, input usingDefault, input activeSet);
   modport selector (input setSelect, input setCode, input pinHigh,
      input pinLow, output activeCode, output usingDefault,
      output activeSet);
endinterface

// File: shared/limiting_amp_pkg.sv
// Purpose: constants shared by the limiting amplifier configuration bank
// Assumes: byte-wide register port driven by the two-wire protocol engine
// Notes: all offsets are byte addresses on the serial interface
package limiting_amp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LEVEL_W = 7;
   localparam int RATE_W = 4;
   localparam int PE_W = 4;
   localparam int NUM_SETS = 4;

   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_SLICE = 8'h01;
   localparam logic [7:0] OFF_PREEMPH = 8'h02;
   localparam logic [7:0] OFF_LEVEL_A = 8'h08;
   localparam logic [7:0] OFF_LEVEL_B = 8'h09;
   localparam logic [7:0] OFF_LEVEL_C = 8'h0A;
   localparam logic [7:0] OFF_LEVEL_D = 8'h0B;
   localparam logic [7:0] OFF_RATE_RB = 8'h0E;
   localparam logic [7:0] OFF_LEVEL_RB = 8'h0F;

   // control register fields
   localparam int BIT_MUTE = 3;
   localparam int BIT_RANGE = 2;
   localparam int BIT_OC_OFF = 1;
   localparam int BIT_IF_OFF = 0;
   localparam logic [3:0] CONTROL_MASK = 4'hF;
   // level set fields
   localparam int BIT_SET_SELECT = 7;

   localparam logic [3:0] RST_CONTROL = 4'h0;
   localparam logic [7:0] RST_SLICE = 8'h80;
   localparam logic [3:0] RST_PREEMPH = 4'h0;
   localparam logic [7:0] RST_LEVEL = 8'h00;
   localparam logic [7:0] SLICE_ZERO = 8'h80;

   // which level set the rate pins pick
   typedef enum logic [1:0] {
      SET_A = 2'b00,
      SET_B = 2'b01,
      SET_C = 2'b10,
      SET_D = 2'b11
   } level_set_e;
endpackage

// File: src/limiting_amp_config_regs.sv
// Purpose: configuration and readback registers of the limiting amplifier
// Assumes: protocol engine presents one byte access per strobe on mclk
// Notes: rate pins are asynchronous and pass two flip-flops
//
// Contract
// [R1] output_mute 1 mutes data outputs, 0 drives them normally.
// [R2] sig_loss_range 1 selects high assert range, 0 low range.
// [R3] offset_cancel_off 1 turns cancellation off, 0 keeps it on.
// [R4] serial_if_off 1 stops serial responses; resets to 0.
// [R5] slice_shift 128 zero, 1 max positive, 255 max negative.
// [R6] preemphasis code decodes to 0..8 dB per fixed table.
// [R7] level set A at 0x08: select bit 7, code bits 6..0.
// [R8] level sets B, C, D at 0x09, 0x0A, 0x0B, same layout.
// [R9] 0x0E bits 3..0 report the rate setting in effect.
// [R10] 0x0F bits 6..0 report the assert level in effect.
// [R11] select 1 uses set code; select 0 uses default level.
// [R12] pins 00 pick set A; low 1 high 0 pick set B.
// [R13] pins 11 pick set C; high 1 low 0 or floating pick D.
// [R14] unused bits read zero; read-only and unused bits ignore writes.
`timescale 1ns/100ps
module limiting_amp_config_regs #(
   parameter logic [6:0] DEFAULT_LEVEL_CODE = 7'h00
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   output logic [7:0] regReadData,
   output logic regReadValid,
   output logic serialIfEnable,
   input wire logic [3:0] activeRateCode,
   input wire logic ratePinHigh,
   input wire logic ratePinLow,
   output logic outputMute,
   output logic sigLossRange,
   output logic offsetCancelOff,
   output logic sliceNegative,
   output logic [7:0] sliceMagnitude,
   output logic [3:0] preemphasisDb,
   output logic [6:0] activeLevelCode,
   output logic levelDefaultInUse
);
   ////////////////////////////////////////////////////////////////////////
   level_select_if lsel ();

   logic [3:0] control;
   logic [7:0] sliceShift;
   logic [3:0] preemphasisCode;
   logic [7:0] levelSet [limiting_amp_pkg::NUM_SETS];
   logic [1:0] pinHighSync;
   logic [1:0] pinLowSync;
   logic [7:0] next_regReadData;
   logic next_regReadValid;
   logic [3:0] next_control;
   logic [7:0] next_sliceShift;
   logic [3:0] next_preemphasisCode;
   logic [7:0] next_levelSet [limiting_amp_pkg::NUM_SETS];
   logic accessOk;

   ////////////////////////////////////////////////////////////////////////
   // rate pins come from the board, so synchronise before decoding
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pinHighSync <= 2'b00;
         pinLowSync <= 2'b00;
      end else begin
         pinHighSync <= {pinHighSync[0], ratePinHigh};
         pinLowSync <= {pinLowSync[0], ratePinLow};
      end
   end

   assign lsel.pinHigh = pinHighSync[1];
   assign lsel.pinLow = pinLowSync[1];

   genvar gi;
   generate
      for (gi = 0; gi < limiting_amp_pkg::NUM_SETS; gi++) begin : g_set
         assign lsel.setSelect[gi] =
            levelSet[gi][limiting_amp_pkg::BIT_SET_SELECT];
         assign lsel.setCode[gi] = levelSet[gi][6:0];
      end
   endgenerate

   sig_loss_level_mux #(
      .DEFAULT_LEVEL_CODE(DEFAULT_LEVEL_CODE)
   ) u_level_mux (
      .sel(lsel)
   );

   ////////////////////////////////////////////////////////////////////////
   // once switched off the interface cannot be revived except by reset
   assign accessOk = !control[limiting_amp_pkg::BIT_IF_OFF]; // R4

   always_comb begin
      next_control = control;
      next_sliceShift = sliceShift;
      next_preemphasisCode = preemphasisCode;
      for (int i = 0; i < limiting_amp_pkg::NUM_SETS; i++) begin
         next_levelSet[i] = levelSet[i];
      end
      if (regWrite && accessOk) begin
         if (regAddr == limiting_amp_pkg::OFF_CONTROL) begin
            next_control = regWriteData[3:0]; // R14
         end else if (regAddr == limiting_amp_pkg::OFF_SLICE) begin
            next_sliceShift = regWriteData;
         end else if (regAddr == limiting_amp_pkg::OFF_PREEMPH) begin
            next_preemphasisCode = regWriteData[3:0]; // R14
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_A) begin
            next_levelSet[0] = regWriteData; // R7
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_B) begin
            next_levelSet[1] = regWriteData; // R8
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_C) begin
            next_levelSet[2] = regWriteData; // R8
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_D) begin
            next_levelSet[3] = regWriteData; // R8
         end
      end
   end

   always_comb begin
      next_regReadValid = regRead && accessOk; // R4
      next_regReadData = 8'h00;
      if (regRead && accessOk) begin
         if (regAddr == limiting_amp_pkg::OFF_CONTROL) begin
            next_regReadData = {4'h0, control}; // R14
         end else if (regAddr == limiting_amp_pkg::OFF_SLICE) begin
            next_regReadData = sliceShift;
         end else if (regAddr == limiting_amp_pkg::OFF_PREEMPH) begin
            next_regReadData = {4'h0, preemphasisCode}; // R14
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_A) begin
            next_regReadData = levelSet[0]; // R7
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_B) begin
            next_regReadData = levelSet[1]; // R8
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_C) begin
            next_regReadData = levelSet[2]; // R8
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_D) begin
            next_regReadData = levelSet[3]; // R8
         end else if (regAddr == limiting_amp_pkg::OFF_RATE_RB) begin
            next_regReadData = {4'h0, activeRateCode}; // R9
         end else if (regAddr == limiting_amp_pkg::OFF_LEVEL_RB) begin
            next_regReadData = {1'b0, lsel.activeCode}; // R10
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         control <= limiting_amp_pkg::RST_CONTROL; // R4
         sliceShift <= limiting_amp_pkg::RST_SLICE;
         preemphasisCode <= limiting_amp_pkg::RST_PREEMPH;
         for (int i = 0; i < limiting_amp_pkg::NUM_SETS; i++) begin
            levelSet[i] <= limiting_amp_pkg::RST_LEVEL;
         end
         regReadData <= 8'h00;
         regReadValid <= 1'b0;
      end else begin
         control <= next_control;
         sliceShift <= next_sliceShift;
         preemphasisCode <= next_preemphasisCode;
         for (int i = 0; i < limiting_amp_pkg::NUM_SETS; i++) begin
            levelSet[i] <= next_levelSet[i];
         end
         regReadData <= next_regReadData;
         regReadValid <= next_regReadValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog controls, registered so the front end sees clean levels
   function automatic logic [3:0] decode_preemphasis(input logic [3:0] c);
      logic [3:0] db;
      db = 4'h0;
      unique case (c)
         4'b0000: db = 4'h0;
         4'b0001, 4'b0010: db = 4'h1;
         4'b0011: db = 4'h2;
         4'b0100: db = 4'h3;
         4'b0101, 4'b0110: db = 4'h4;
         4'b0111, 4'b1000, 4'b1001, 4'b1010, 4'b1011: db = 4'h5;
         4'b1100: db = 4'h6;
         4'b1101, 4'b1110: db = 4'h7;
         default: db = 4'h8;
      endcase
      return db;
   endfunction

   logic next_sliceNegative;
   logic [7:0] next_sliceMagnitude;

   always_comb begin
      // code 0 is undefined; treated as one past maximum positive shift
      if (sliceShift >= limiting_amp_pkg::SLICE_ZERO) begin
         next_sliceNegative = (sliceShift != limiting_amp_pkg::SLICE_ZERO);
         next_sliceMagnitude = sliceShift - limiting_amp_pkg::SLICE_ZERO; // R5
      end else begin
         next_sliceNegative = 1'b0;
         next_sliceMagnitude = limiting_amp_pkg::SLICE_ZERO - sliceShift; // R5
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         outputMute <= 1'b0;
         sigLossRange <= 1'b0;
         offsetCancelOff <= 1'b0;
         serialIfEnable <= 1'b1;
         sliceNegative <= 1'b0;
         sliceMagnitude <= 8'h00;
         preemphasisDb <= 4'h0;
         activeLevelCode <= DEFAULT_LEVEL_CODE; // R11
         levelDefaultInUse <= 1'b1;
      end else begin
         outputMute <= control[limiting_amp_pkg::BIT_MUTE]; // R1
         sigLossRange <= control[limiting_amp_pkg::BIT_RANGE]; // R2
         offsetCancelOff <= control[limiting_amp_pkg::BIT_OC_OFF]; // R3
         // from the next value, so the flag never lags the lock itself
         serialIfEnable <= !next_control[limiting_amp_pkg::BIT_IF_OFF]; // R4
         sliceNegative <= next_sliceNegative;
         sliceMagnitude <= next_sliceMagnitude;
         preemphasisDb <= decode_preemphasis(preemphasisCode); // R6
         activeLevelCode <= lsel.activeCode; // R11
         levelDefaultInUse <= lsel.usingDefault;
      end
   end
endmodule // limiting_amp_config_regs

// File: src/sig_loss_level_mux.sv
// Purpose: picks the loss-of-signal assert level from the rate pins
// Assumes: pins already synchronised to mclk
// Notes: default code stands for the fixed default assert level
`timescale 1ns/100ps
module sig_loss_level_mux #(
   parameter logic [6:0] DEFAULT_LEVEL_CODE = 7'h00
) (
   level_select_if.selector sel
);
   always_comb begin
      unique case ({sel.pinHigh, sel.pinLow})
         2'b00: sel.activeSet = limiting_amp_pkg::SET_A; // R12
         2'b01: sel.activeSet = limiting_amp_pkg::SET_B; // R12
         2'b11: sel.activeSet = limiting_amp_pkg::SET_C; // R13
         default: sel.activeSet = limiting_amp_pkg::SET_D; // R13
      endcase
   end

   always_comb begin
      sel.usingDefault = !sel.setSelect[sel.activeSet];
      if (sel.setSelect[sel.activeSet]) begin
         sel.activeCode = sel.setCode[sel.activeSet]; // R11
      end else begin
         sel.activeCode = DEFAULT_LEVEL_CODE; // R11
      end
   end
endmodule // sig_loss_level_mux

// File: tb/host_bus_model.sv
// Purpose: host side of the register port, one byte per strobe
// Assumes: strobes launched just after a rising mclk edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/100ps
module host_bus_model (
   input wire logic mclk,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   output logic regWrite = 1'b0,
   output logic regRead = 1'b0,
   output logic [7:0] regAddr = 8'h00,
   output logic [7:0] regWriteData = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWriteData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
         output logic v);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      regAddr <= ~a;
      @(posedge mclk);
      v = regReadValid;
      d = regReadData;
   endtask
endmodule // host_bus_model

// File: tb/limiting_amp_monitor.sv
// Purpose: port-level checks of the limiting amplifier register bank
// Assumes: one mclk domain, rst_n synchronous active low
// Notes: bound to every instance of the bank
`timescale 1ns/100ps
module limiting_amp_monitor #(
   parameter logic [6:0] DEFAULT_LEVEL_CODE = 7'h00
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   input wire logic serialIfEnable,
   input wire logic [3:0] activeRateCode,
   input wire logic ratePinHigh,
   input wire logic ratePinLow,
   input wire logic outputMute,
   input wire logic sigLossRange,
   input wire logic offsetCancelOff,
   input wire logic sliceNegative,
   input wire logic [7:0] sliceMagnitude,
   input wire logic [3:0] preemphasisDb,
   input wire logic [6:0] activeLevelCode,
   input wire logic levelDefaultInUse
);
   logic wr;
   logic rdOk;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // the bank also serves a read that meets a write; only lone reads are checked
   assign wr = regWrite && serialIfEnable;
   assign rdOk = regRead && !regWrite && serialIfEnable;
   property p_read_answer; rdOk |=> regReadValid; endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered");
   property p_idle_zero; !regReadValid |-> regReadData == 8'h00; endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("read data not zero while idle");
   property p_locked; !serialIfEnable |=> !serialIfEnable && !regReadValid;
   endproperty
   a_locked: assert property (p_locked)
      else $error("interface answered after disable");
   property p_mute;
      wr && regAddr == 8'h00 |=> ##1 outputMute == $past(regWriteData[3], 2);
   endproperty
   a_mute: assert property (p_mute)
      else $error("mute does not follow control");
   property p_range;
      wr && regAddr == 8'h00 |=> ##1 sigLossRange == $past(regWriteData[2], 2);
   endproperty
   a_range: assert property (p_range)
      else $error("range does not follow control");
   property p_oc; wr && regAddr == 8'h00 |=> ##1
      offsetCancelOff == $past(regWriteData[1], 2); endproperty
   a_oc: assert property (p_oc)
      else $error("offset cancel does not follow control");
   property p_slice; wr && regAddr == 8'h01 |=> ##1
      sliceNegative == ($past(regWriteData, 2) > 8'h80); endproperty
   a_slice: assert property (p_slice)
      else $error("slice sign wrong");
   property p_rate_rb; rdOk && regAddr == 8'h0E |=>
      regReadData == {4'h0, $past(activeRateCode)}; endproperty
   a_rate_rb: assert property (p_rate_rb)
      else $error("rate readback wrong");
   property p_level_rb; rdOk && regAddr == 8'h0F |=> !regReadData[7];
   endproperty
   a_level_rb: assert property (p_level_rb)
      else $error("level readback top bit set");
   property p_default;
      levelDefaultInUse |-> activeLevelCode == DEFAULT_LEVEL_CODE;
   endproperty
   a_default: assert property (p_default)
      else $error("default level not in use");
   c_read: cover property (regReadValid);
   c_lock: cover property (!serialIfEnable);
   c_set_level: cover property (!levelDefaultInUse);
endmodule // limiting_amp_monitor

bind limiting_amp_config_regs limiting_amp_monitor #(
   .DEFAULT_LEVEL_CODE(DEFAULT_LEVEL_CODE)) i_mon (.*);

// File: tb/testbench.sv
// Purpose: self-checking bench of the limiting amplifier register bank
// Assumes: host model issues strobes, bench drives pins and rate code
// Notes: derived outputs sampled two edges after the write
`timescale 1ns/100ps
module testbench;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ratePinHigh = 1'b0;
   logic ratePinLow = 1'b0;
   logic [3:0] activeRateCode = 4'h0;
   logic regWrite, regRead, regReadValid, serialIfEnable, outputMute;
   logic sigLossRange, offsetCancelOff, sliceNegative, levelDefaultInUse;
   logic [7:0] regAddr, regWriteData, regReadData, sliceMagnitude;
   logic [3:0] preemphasisDb;
   logic [6:0] activeLevelCode;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #2 mclk = ~mclk;
   host_bus_model i_host (.mclk(mclk), .regReadData(regReadData),
      .regReadValid(regReadValid), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWriteData(regWriteData));
   // nonzero default so it cannot pass for a reset value
   limiting_amp_config_regs #(.DEFAULT_LEVEL_CODE(7'h2A)) i_dut (
      .mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWriteData(regWriteData),
      .regReadData(regReadData), .regReadValid(regReadValid),
      .serialIfEnable(serialIfEnable), .activeRateCode(activeRateCode),
      .ratePinHigh(ratePinHigh), .ratePinLow(ratePinLow),
      .outputMute(outputMute), .sigLossRange(sigLossRange),
      .offsetCancelOff(offsetCancelOff), .sliceNegative(sliceNegative),
      .sliceMagnitude(sliceMagnitude), .preemphasisDb(preemphasisDb),
      .activeLevelCode(activeLevelCode),
      .levelDefaultInUse(levelDefaultInUse));
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_host.rd(a, d, v);
      chk("read valid", {7'h00, v}, 8'h01);
      chk("read data", d, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk);
   endtask
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_reset();
      rdchk(8'h00, 8'h00);
      rdchk(8'h01, 8'h80);
      chk("if enable", {7'h00, serialIfEnable}, 8'h01);
      chk("default", {7'h00, levelDefaultInUse}, 8'h01);
      $display("reset test done");
   endtask
   task automatic t_control();
      i_host.wr(8'h00, 8'hFE);
      settle();
      chk("mute", {7'h00, outputMute}, 8'h01);
      chk("range", {7'h00, sigLossRange}, 8'h01);
      chk("oc off", {7'h00, offsetCancelOff}, 8'h01);
      rdchk(8'h00, 8'h0E);
      i_host.wr(8'h00, 8'h04);
      settle();
      chk("mute", {7'h00, outputMute}, 8'h00);
      chk("oc off", {7'h00, offsetCancelOff}, 8'h00);
      $display("control test done");
   endtask
   task automatic t_slice();
      logic [7:0] codes [6] = '{8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF, 8'h00};
      logic [7:0] c;
      foreach (codes[i]) begin
         c = codes[i];
         i_host.wr(8'h01, c);
         settle();
         chk("slice sign", {7'h00, sliceNegative}, {7'h00, c > 8'h80});
         chk("slice mag", sliceMagnitude,
            c >= 8'h80 ? c - 8'h80 : 8'h80 - c);
      end
      $display("slice test done");
   endtask
   task automatic t_preemph();
      // undefined codes round down to the defined code below
      logic [3:0] db [16] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4,
         4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8};
      for (int c = 0; c < 16; c++) begin
         i_host.wr(8'h02, {4'hF, c[3:0]});
         settle();
         chk("preemphasis", {4'h0, preemphasisDb}, {4'h0, db[c]});
      end
      rdchk(8'h02, 8'h0F);
      $display("preemphasis test done");
   endtask
   task automatic t_levels();
      logic [1:0] pins [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
      logic [7:0] lvl [4] = '{8'h05, 8'h06, 8'h07, 8'h2A};
      for (int i = 0; i < 4; i++)
         i_host.wr(8'h08 + i[7:0], i < 3 ? 8'h80 | lvl[i] : 8'h08);
      rdchk(8'h08, 8'h85);
      rdchk(8'h0B, 8'h08);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {ratePinHigh, ratePinLow} <= pins[i];
         repeat (5) @(posedge mclk);
         chk("level", {1'b0, activeLevelCode}, lvl[i]);
         chk("default", {7'h00, levelDefaultInUse}, {7'h00, i == 3});
         rdchk(8'h0F, lvl[i]);
      end
      $display("level test done");
   endtask
   task automatic t_rate();
      @(posedge mclk);
      activeRateCode <= 4'hA;
      rdchk(8'h0E, 8'h0A);
      i_host.wr(8'h0E, 8'hFF);
      rdchk(8'h0E, 8'h0A);
      rdchk(8'h05, 8'h00);
      $display("rate test done");
   endtask
   task automatic t_lock();
      logic [7:0] d;
      logic v;
      i_host.wr(8'h00, 8'h01);
      settle();
      chk("if enable", {7'h00, serialIfEnable}, 8'h00);
      i_host.rd(8'h08, d, v);
      chk("refused valid", {7'h00, v}, 8'h00);
      chk("refused data", d, 8'h00);
      i_host.wr(8'h00, 8'h08);
      settle();
      chk("refused mute", {7'h00, outputMute}, 8'h00);
      $display("lock test done");
   endtask
   always @(posedge mclk) begin
      cycles++;
      // far above the fewer than two hundred cycles the tests need
      if (cycles == 5000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_control();
      t_slice();
      t_preemph();
      t_levels();
      t_rate();
      t_lock();
      finish_test();
   end
endmodule // testbench
